// [logic/asrs_pkg.sv]
// Constants, field layouts and types of the converter serial readout block.
// Assumes a 10 MHz system clock and a host that clocks the link from outside.
//
// What this block does
// - Results are offset binary, midscale is top bit
// - Code is half scale times input gain ratio plus one
// - Bridge switch closed while powerdown pin high
// - Link is serial clock in, ready/data out
// - Ready line low once new word loaded
// - Word: 20-bit result, four zeros, status byte
// - Ready line returns high after word read
// - Unread word: line high before register update
// - Each conversion read once, register always updated
// - Conversion end resets shifter, loads new word
// - Ready line tristated while powerdown pin low
// - After power-up wait 1 ms, then settle, convert
// - Line high from power-up until first conversion
// - Filter or gain change restarts settling, line high
// - Status shows ready, filter and gain settings
// - Error bit set when input out of range
// - Status carries a fixed two-bit identity code
// - Transfer check pattern is 01
// - Filter pin low 16.7 Hz, high 10 Hz
// - Settling 300 ms or 120 ms by filter
// - Gain pin low gain 128, high gain 1

package asrs_pkg;

   // Timing figures in their own units
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned STARTUP_US = 1000;
   localparam int unsigned CONV10_MS = 100;
   localparam int unsigned CONV16_MS = 60;
   localparam int unsigned SETTLE10_MS = 300;
   localparam int unsigned SETTLE16_MS = 120;
   localparam int unsigned BLANK_US = 100;
   localparam int unsigned PWRDN_MIN_NS = 100;

   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] STARTUP_CYC = CNT_W'(STARTUP_US * (CLK_HZ / 1_000_000));
   localparam logic [CNT_W-1:0] CONV10_CYC = CNT_W'(CONV10_MS * (CLK_HZ / 1000));
   localparam logic [CNT_W-1:0] CONV16_CYC = CNT_W'(CONV16_MS * (CLK_HZ / 1000));
   localparam logic [CNT_W-1:0] SETTLE10_CYC = CNT_W'(SETTLE10_MS * (CLK_HZ / 1000));
   localparam logic [CNT_W-1:0] SETTLE16_CYC = CNT_W'(SETTLE16_MS * (CLK_HZ / 1000));
   localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'(BLANK_US * (CLK_HZ / 1_000_000));

   // Conversion arithmetic
   localparam int CODE_W = 20;
   localparam int AIN_W = 24;
   localparam int GAIN1_SHIFT = 4;
   localparam int GAIN128_SHIFT = 3;
   localparam logic signed [31:0] CODE_MID = 32'sh0008_0000;
   localparam logic signed [31:0] CODE_MAX = 32'sh000f_ffff;
   localparam logic [CODE_W-1:0] CODE_ZERO = 20'h0_0000;
   localparam logic [CODE_W-1:0] CODE_ONES = 20'hf_ffff;

   // Output word
   localparam logic [5:0] WORD_BITS = 6'h20;
   localparam logic [4:0] WORD_MSB = 5'h1f;
   localparam logic [1:0] CHECK_PATTERN = 2'h1;
   localparam logic [3:0] PAD_ZERO = 4'h0;

   // Register map, byte addresses
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] REG_AIN = 8'h00;
   localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] REG_WORD = 8'h08;
   localparam logic [ADR_W-1:0] REG_COUNT = 8'h0c;

   // Status register fields
   localparam int ST_AVAIL = 0;
   localparam int ST_BRIDGE = 1;
   localparam int ST_DRIVE = 2;
   localparam int ST_RUN = 3;
   localparam int ST_SETTLE = 4;
   localparam int ST_FILT = 5;
   localparam int ST_GAIN = 6;
   localparam int ST_ERR = 7;

   typedef struct packed {
      logic ready_n;
      logic filter;
      logic err;
      logic [1:0] identity_bits;
      logic gain;
      logic [1:0] transfer_check_pattern;
   } asrs_status_t;

   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [3:0] pad;
      asrs_status_t status;
   } asrs_word_t;

   typedef enum logic [1:0] {
      PH_OFF,
      PH_START,
      PH_SETTLE,
      PH_RUN
   } asrs_phase_t;

endpackage

// [logic/asrs_code.sv]
// Turns a signed input sample into the offset-binary converter code.
// Assumes the sample is input over reference scaled by two to the 23.
`timescale 1ns/1ns

module asrs_code (
   input wire logic signed [asrs_pkg::AIN_W-1:0] ain,
   input wire logic gain_unity,
   output logic [asrs_pkg::CODE_W-1:0] code,
   output logic over
);

   logic signed [31:0] wide;
   logic signed [31:0] scaled;
   logic signed [31:0] biased;

   assign wide = 32'(ain);
   // Half scale times input times gain, plus half scale
   assign scaled = gain_unity ? (wide >>> asrs_pkg::GAIN1_SHIFT) : (wide <<< asrs_pkg::GAIN128_SHIFT);
   assign biased = scaled + asrs_pkg::CODE_MID;

   always_comb begin
      if (biased < 0) begin
         code = asrs_pkg::CODE_ZERO;
         over = 1'b1;
      end else if (biased > asrs_pkg::CODE_MAX) begin
         code = asrs_pkg::CODE_ONES;
         over = 1'b1;
      end else begin
         code = biased[asrs_pkg::CODE_W-1:0];
         over = 1'b0;
      end
   end

endmodule

// [logic/asrs_top.sv]
// Converter readout: power sequencing, conversion timing, serial word out.
// Assumes host drives serial_clk and pins asynchronously; Wishbone on clk.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ns

module asrs_top #(
   parameter logic [asrs_pkg::CNT_W-1:0] STARTUP_CYC = asrs_pkg::STARTUP_CYC,
   parameter logic [asrs_pkg::CNT_W-1:0] CONV10_CYC = asrs_pkg::CONV10_CYC,
   parameter logic [asrs_pkg::CNT_W-1:0] CONV16_CYC = asrs_pkg::CONV16_CYC,
   parameter logic [asrs_pkg::CNT_W-1:0] SETTLE10_CYC = asrs_pkg::SETTLE10_CYC,
   parameter logic [asrs_pkg::CNT_W-1:0] SETTLE16_CYC = asrs_pkg::SETTLE16_CYC,
   parameter logic [asrs_pkg::CNT_W-1:0] BLANK_CYC = asrs_pkg::BLANK_CYC,
   parameter logic [1:0] IDENTITY = 2'h2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [asrs_pkg::ADR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   input wire logic powerdown_reset_n,
   input wire logic filter_sel,
   input wire logic gain_sel,
   input wire logic serial_clk,
   output logic data_out_ready_n,
   output logic data_out_ready_oe,
   output logic bridge_switch
);

   // IDENTITY default is arbitrary

   // Pin synchronisers: stage one feeds stage two only
   logic [3:0] pin_a_r;
   logic [3:0] pin_b_r;
   logic sclk_d_r;
   logic pd_s;
   logic filt_s;
   logic gain_s;
   logic sclk_s;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Serial clock idles high, so no false edge after reset
         pin_a_r <= 4'h8;
         pin_b_r <= 4'h8;
         sclk_d_r <= 1'b1;
      end else begin
         pin_a_r <= {serial_clk, gain_sel, filter_sel, powerdown_reset_n};
         pin_b_r <= pin_a_r;
         sclk_d_r <= pin_b_r[3];
      end
   end

   assign pd_s = pin_b_r[0];
   assign filt_s = pin_b_r[1];
   assign gain_s = pin_b_r[2];
   assign sclk_s = pin_b_r[3];
   assign sclk_rise = sclk_s && !sclk_d_r;
   assign sclk_fall = !sclk_s && sclk_d_r;

   function automatic logic [asrs_pkg::CNT_W-1:0] settle_of(input logic f10);
      settle_of = f10 ? SETTLE10_CYC : SETTLE16_CYC;
   endfunction

   function automatic logic [asrs_pkg::CNT_W-1:0] period_of(input logic f10);
      period_of = f10 ? CONV10_CYC : CONV16_CYC;
   endfunction

   function automatic logic reg_is(input logic [asrs_pkg::ADR_W-1:0] adr, input logic [asrs_pkg::ADR_W-1:0] off);
      reg_is = (adr == off);
   endfunction

   // Conversion timing
   asrs_pkg::asrs_phase_t phase_r;
   logic [asrs_pkg::CNT_W-1:0] cnt_r;
   logic filt_r;
   logic gain_r;
   logic cfg_chg;
   logic conv_done;
   logic blank;

   assign cfg_chg = (phase_r == asrs_pkg::PH_SETTLE || phase_r == asrs_pkg::PH_RUN) &&
                    (filt_s != filt_r || gain_s != gain_r);
   assign conv_done = (phase_r == asrs_pkg::PH_SETTLE || phase_r == asrs_pkg::PH_RUN) &&
                      !cfg_chg && cnt_r == '0;
   assign blank = phase_r == asrs_pkg::PH_RUN && cnt_r != '0 && cnt_r <= BLANK_CYC;

   always_ff @(posedge clk) begin
      if (sys_rst || !pd_s) begin
         // Power-down resets filter and timing
         phase_r <= asrs_pkg::PH_OFF;
         cnt_r <= '0;
         filt_r <= 1'b0;
         gain_r <= 1'b0;
      end else begin
         case (phase_r)
            asrs_pkg::PH_OFF: begin
               phase_r <= asrs_pkg::PH_START;
               cnt_r <= STARTUP_CYC - 1'b1;
               filt_r <= filt_s;
               gain_r <= gain_s;
            end
            asrs_pkg::PH_START: begin
               filt_r <= filt_s;
               gain_r <= gain_s;
               if (cnt_r == '0) begin
                  phase_r <= asrs_pkg::PH_SETTLE;
                  cnt_r <= settle_of(filt_s) - 1'b1;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            default: begin
               if (cfg_chg) begin
                  // Restart modulator and filter with new setting
                  phase_r <= asrs_pkg::PH_SETTLE;
                  cnt_r <= settle_of(filt_s) - 1'b1;
                  filt_r <= filt_s;
                  gain_r <= gain_s;
               end else if (cnt_r == '0) begin
                  phase_r <= asrs_pkg::PH_RUN;
                  cnt_r <= period_of(filt_r) - 1'b1;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
         endcase
      end
   end

   // New word from the software-fed input sample
   logic [asrs_pkg::AIN_W-1:0] ain_r;
   logic [asrs_pkg::CODE_W-1:0] code_c;
   logic over_c;
   asrs_pkg::asrs_word_t new_word;

   asrs_code u_code (
      .ain(ain_r),
      .gain_unity(gain_r),
      .code(code_c),
      .over(over_c)
   );

   always_comb begin
      new_word.code = code_c;
      new_word.pad = asrs_pkg::PAD_ZERO;
      new_word.status.ready_n = 1'b0;
      new_word.status.filter = filt_r;
      new_word.status.err = over_c;
      new_word.status.identity_bits = IDENTITY;
      new_word.status.gain = gain_r;
      new_word.status.transfer_check_pattern = asrs_pkg::CHECK_PATTERN;
   end

   // Serial readout
   asrs_pkg::asrs_word_t word_r;
   logic avail_r;
   logic [5:0] bit_cnt_r;
   logic [4:0] bit_idx;
   logic [15:0] conv_cnt_r;

   assign bit_idx = asrs_pkg::WORD_MSB - bit_cnt_r[4:0];

   always_ff @(posedge clk) begin
      if (sys_rst || !pd_s) begin
         word_r <= '0;
         avail_r <= 1'b0;
         bit_cnt_r <= '0;
         data_out_ready_n <= 1'b1;
         data_out_ready_oe <= 1'b0;
         bridge_switch <= 1'b0;
      end else begin
         data_out_ready_oe <= 1'b1;
         bridge_switch <= 1'b1;
         if (conv_done) begin
            // Any partial shift is dropped
            word_r <= new_word;
            avail_r <= 1'b1;
            bit_cnt_r <= '0;
            data_out_ready_n <= 1'b0;
         end else if (phase_r == asrs_pkg::PH_OFF || phase_r == asrs_pkg::PH_START || cfg_chg) begin
            avail_r <= 1'b0;
            bit_cnt_r <= '0;
            data_out_ready_n <= 1'b1;
         end else if (blank && avail_r) begin
            avail_r <= 1'b0;
            bit_cnt_r <= '0;
            data_out_ready_n <= 1'b1;
         end else if (avail_r && sclk_fall && bit_cnt_r != asrs_pkg::WORD_BITS) begin
            data_out_ready_n <= word_r[bit_idx];
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end else if (avail_r && sclk_rise && bit_cnt_r == asrs_pkg::WORD_BITS) begin
            // Last bit sampled: word consumed
            avail_r <= 1'b0;
            data_out_ready_n <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_cnt_r <= 16'h0000;
      end else if (conv_done) begin
         conv_cnt_r <= conv_cnt_r + 1'b1;
      end
   end

   // Wishbone slave, one wait state
   logic wb_hit;
   logic [31:0] rd_c;

   assign wb_hit = wb_cyc && wb_stb && !wb_ack;

   always_comb begin
      rd_c = 32'h0000_0000;
      if (reg_is(wb_adr, asrs_pkg::REG_AIN)) begin
         rd_c = {{(32 - asrs_pkg::AIN_W){1'b0}}, ain_r};
      end else if (reg_is(wb_adr, asrs_pkg::REG_STATUS)) begin
         rd_c[asrs_pkg::ST_AVAIL] = avail_r;
         rd_c[asrs_pkg::ST_BRIDGE] = bridge_switch;
         rd_c[asrs_pkg::ST_DRIVE] = data_out_ready_oe;
         rd_c[asrs_pkg::ST_RUN] = phase_r == asrs_pkg::PH_RUN;
         rd_c[asrs_pkg::ST_SETTLE] = phase_r == asrs_pkg::PH_SETTLE;
         rd_c[asrs_pkg::ST_FILT] = filt_r;
         rd_c[asrs_pkg::ST_GAIN] = gain_r;
         rd_c[asrs_pkg::ST_ERR] = word_r.status.err;
      end else if (reg_is(wb_adr, asrs_pkg::REG_WORD)) begin
         rd_c = word_r;
      end else if (reg_is(wb_adr, asrs_pkg::REG_COUNT)) begin
         rd_c = {16'h0000, conv_cnt_r};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
         ain_r <= '0;
      end else begin
         wb_ack <= wb_hit;
         if (wb_hit && !wb_we) begin
            wb_dat_r <= rd_c;
         end
         if (wb_hit && wb_we && reg_is(wb_adr, asrs_pkg::REG_AIN)) begin
            for (int b = 0; b < 3; b++) begin
               if (wb_sel[b]) begin
                  ain_r[b*8 +: 8] <= wb_dat_w[b*8 +: 8];
               end
            end
         end
      end
   end

   // Checks
   a_pd_float:
   assert property (@(posedge clk) disable iff (sys_rst)
      !pd_s |=> !data_out_ready_oe && !bridge_switch)
      else $error("line driven or bridge closed in power-down");

   a_bridge_close:
   assert property (@(posedge clk) disable iff (sys_rst)
      pd_s && $past(pd_s) |=> bridge_switch)
      else $error("bridge open while powered");

   a_powerup_high:
   assert property (@(posedge clk) disable iff (sys_rst)
      $rose(pd_s) |=> data_out_ready_oe && data_out_ready_n && !avail_r)
      else $error("line not high after power-up");

   a_startup_count:
   assert property (@(posedge clk) disable iff (sys_rst)
      phase_r == asrs_pkg::PH_START && cnt_r != '0 && pd_s
      |=> phase_r == asrs_pkg::PH_START && cnt_r == $past(cnt_r) - 1'b1)
      else $error("startup wait not counted");

   a_settle_load:
   assert property (@(posedge clk) disable iff (sys_rst)
      phase_r == asrs_pkg::PH_START && cnt_r == '0 && pd_s
      |=> phase_r == asrs_pkg::PH_SETTLE && cnt_r == settle_of($past(filt_s)) - 1'b1)
      else $error("settling time wrong");

   a_cfg_restart:
   assert property (@(posedge clk) disable iff (sys_rst)
      cfg_chg && pd_s |=> phase_r == asrs_pkg::PH_SETTLE && data_out_ready_n && !avail_r)
      else $error("setting change did not restart");

   a_ready_low:
   assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && pd_s |=> !data_out_ready_n && avail_r && bit_cnt_r == '0)
      else $error("ready not shown after conversion");

   a_word_layout:
   assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && pd_s |=> word_r.pad == asrs_pkg::PAD_ZERO && word_r.code == $past(code_c))
      else $error("word layout wrong");

   a_status_bits:
   assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && pd_s |=> !word_r.status.ready_n && word_r.status.filter == filt_r
                            && word_r.status.gain == gain_r)
      else $error("status bits wrong");

   a_check_pattern:
   assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && pd_s |=> word_r.status.transfer_check_pattern == asrs_pkg::CHECK_PATTERN
                            && word_r.status.identity_bits == IDENTITY)
      else $error("pattern or identity wrong");

   a_shift_msb:
   assert property (@(posedge clk) disable iff (sys_rst)
      pd_s && !conv_done && !blank && !cfg_chg && avail_r && sclk_fall && bit_cnt_r == '0
      && phase_r == asrs_pkg::PH_RUN |=> data_out_ready_n == word_r[asrs_pkg::WORD_MSB])
      else $error("first bit not MSB");

   a_read_once:
   assert property (@(posedge clk) disable iff (sys_rst)
      pd_s && !conv_done && !blank && !cfg_chg && avail_r && sclk_rise
      && bit_cnt_r == asrs_pkg::WORD_BITS && phase_r == asrs_pkg::PH_RUN
      |=> data_out_ready_n && !avail_r)
      else $error("line not released after read");

   a_blank_high:
   assert property (@(posedge clk) disable iff (sys_rst)
      pd_s && blank && !cfg_chg |=> data_out_ready_n && !avail_r)
      else $error("line low in update window");

endmodule

// [tb/asrs_host_model.sv]
// Host side of the serial link: clocks out words and samples the line.
// Assumes clk is the bench clock and line is the resolved pin level.
`timescale 1ns/1ns

module asrs_host_model (
   input wire logic clk,
   input wire logic line,
   output logic serial_clk
);
   // Clock idles high and stands still between frames
   initial serial_clk = 1'b1;

   // Falls to shift, samples at end of low phase; a word takes 257 clk
   task automatic clock_bits(input int n, output logic [31:0] w);
      w = 32'h0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         serial_clk <= 1'b0;
         repeat (3) @(posedge clk);
         // Sample just before the rising edge, as a real host does
         @(negedge clk);
         w = {w[30:0], line};
         @(posedge clk);
         serial_clk <= 1'b1;
         repeat (3) @(posedge clk);
      end
      @(posedge clk);
   endtask
endmodule

// [tb/adc_serial_readout_status_tb_top.sv]
// Bench for the converter readout: table of settings, then awkward cases.
// Assumes asrs_top with shortened timing and the host model on the link.
`timescale 1ns/1ns

module adc_serial_readout_status_tb_top;
   typedef struct packed {
      logic f;
      logic g;
      logic [23:0] ain;
      logic [19:0] code;
      logic e;
   } asrs_row_t;
   // Arbitrary identity value
   localparam logic [1:0] ID = 2'h1;
   localparam int S10 = 6000;
   localparam int S16 = 2400;
   localparam int ST = int'(asrs_pkg::STARTUP_CYC);
   logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, q, w;
   logic powerdown_reset_n, filter_sel, gain_sel, serial_clk;
   logic data_out_ready_n, data_out_ready_oe, bridge_switch, flt, line, chg;
   int num_errors, n_tests, c, cyc_cnt;
   asrs_row_t rows [7];

   // Released line shows a level that flips every cycle
   assign line = data_out_ready_oe ? data_out_ready_n : flt;

   asrs_top #(.CONV10_CYC(24'h7d0), .CONV16_CYC(24'h4b0), .SETTLE10_CYC(24'h1770),
      .SETTLE16_CYC(24'h960), .BLANK_CYC(24'h14), .IDENTITY(ID)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
      .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .powerdown_reset_n(powerdown_reset_n), .filter_sel(filter_sel), .gain_sel(gain_sel),
      .serial_clk(serial_clk), .data_out_ready_n(data_out_ready_n),
      .data_out_ready_oe(data_out_ready_oe), .bridge_switch(bridge_switch));

   asrs_host_model i_host (.clk(clk), .line(line), .serial_clk(serial_clk));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      flt <= ~flt;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 80000) begin
         num_errors++;
         final_report();
      end
   end

   function automatic logic [31:0] wexp(logic f, logic g, logic [19:0] cd, logic e);
      return {cd, 4'h0, 1'b0, f, e, ID, g, 2'h1};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_w <= d;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 50);
      r = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (k >= 50) begin
         num_errors++;
         final_report();
      end
   endtask

   task automatic wait_lvl(input logic lv, output int n);
      n = 0;
      while ((data_out_ready_oe !== 1'b1 || data_out_ready_n !== lv) && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) begin
         num_errors++;
         final_report();
      end
   endtask

   task automatic powerup;
      @(posedge clk);
      powerdown_reset_n <= 1'b1;
      repeat (5) @(negedge clk);
      chk({29'h0, data_out_ready_oe, data_out_ready_n, bridge_switch}, 32'h7);
      wait_lvl(1'b0, c);
      chk(32'(c + 5 >= S10 + ST && c + 5 <= S10 + ST + 12), 32'h1);
   endtask

   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      sys_rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, flt} = 4'h0;
      wb_adr = 8'h0;
      wb_sel = 4'hf;
      wb_dat_w = 32'h0;
      powerdown_reset_n = 1'b0;
      filter_sel = 1'b1;
      gain_sel = 1'b1;
      num_errors = 0;
      n_tests = 0;
      cyc_cnt = 0;
      rows = '{'{1'b1, 1'b1, 24'h0, 20'h80000, 1'b0}, '{1'b1, 1'b1, 24'h7fffff, 20'hfffff, 1'b0},
         '{1'b0, 1'b1, 24'h800000, 20'h0, 1'b0}, '{1'b0, 1'b0, 24'h001000, 20'h88000, 1'b0},
         '{1'b0, 1'b0, 24'h010000, 20'hfffff, 1'b1}, '{1'b1, 1'b0, 24'hfe0000, 20'h0, 1'b1},
         '{1'b1, 1'b0, 24'hffe000, 20'h70000, 1'b0}};
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk({30'h0, data_out_ready_oe, bridge_switch}, 32'h0);
      powerup();
      foreach (rows[i]) begin
         chg = (rows[i].f !== filter_sel) || (rows[i].g !== gain_sel);
         wb(1'b1, 8'h00, {8'h0, rows[i].ain}, q);
         filter_sel <= rows[i].f;
         gain_sel <= rows[i].g;
         wait_lvl(1'b0, c);
         if (chg) begin
            chk(32'(c + 2 >= (rows[i].f ? S10 : S16) && c <= (rows[i].f ? S10 : S16) + 12), 32'h1);
         end
         i_host.clock_bits(32, w);
         chk(w, wexp(rows[i].f, rows[i].g, rows[i].code, rows[i].e));
         wb(1'b0, 8'h04, 32'h0, q);
         chk({31'h0, q[0]}, 32'h0);
      end
      // Unread word: line lifts for the blank gap before the update
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, c);
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, c);
      chk(32'(c >= 18 && c <= 24), 32'h1);
      // Partial read abandoned by the next conversion
      i_host.clock_bits(10, w);
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, c);
      i_host.clock_bits(32, w);
      chk(w, wexp(1'b1, 1'b0, 20'h70000, 1'b0));
      i_host.clock_bits(32, w);
      chk(w, 32'hffffffff);
      // Gain change in mid-read gives ones
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, c);
      fork
         i_host.clock_bits(32, w);
         begin
            repeat (100) @(posedge clk);
            gain_sel <= 1'b1;
         end
      join
      chk({16'h0, w[15:0]}, 32'hffff);
      @(posedge clk);
      powerdown_reset_n <= 1'b0;
      repeat (5) @(negedge clk);
      chk({30'h0, data_out_ready_oe, bridge_switch}, 32'h0);
      powerup();
      wb(1'b0, 8'h08, 32'h0, q);
      chk(q, wexp(1'b1, 1'b1, 20'h7fe00, 1'b0));
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
      // Byte lanes: only the low byte of the sample changes
      wb_sel <= 4'h1;
      wb(1'b1, 8'h00, 32'h0000_00ab, q);
      wb_sel <= 4'hf;
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h00ff_e0ab);
      final_report();
   end
endmodule
